// *** hw/gsm_regs.sv ***
// Upper pin status register and read-only measurement result registers
`timescale 1ns/10ps
module gsm_regs #(
	parameter int PIN_COUNT = 8,
	parameter int DATA_WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [DATA_WIDTH-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_WIDTH-1:0] reg_rdata,
	input wire logic [PIN_COUNT-1:0] upper_pin_in,
	output logic [PIN_COUNT-1:0] upper_pin_out,
	output logic [PIN_COUNT-1:0] upper_pin_oe,
	input wire logic [PIN_COUNT-1:0] pin_is_output,
	input wire logic [7:0] pin_cfg_three,
	input wire logic [7:0] pin_cfg_four,
	input wire logic shared_is_aux_nine,
	input wire logic meas_valid,
	input wire logic [3:0] meas_chan,
	input wire logic [DATA_WIDTH-1:0] meas_value
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [PIN_COUNT-1:0] pin_meta;
		logic [PIN_COUNT-1:0] pin_sync;
		logic [PIN_COUNT-1:0] status;
		logic [gsm_pkg::RESULT_COUNT-1:0][DATA_WIDTH-1:0] result;
		logic [DATA_WIDTH-1:0] rdata;
		logic [PIN_COUNT-1:0] pin_out;
		logic [PIN_COUNT-1:0] pin_oe;
	} gsm_state_t;

	gsm_state_t st_ff;
	gsm_state_t nxt_st;
	logic [PIN_COUNT-1:0] pol;

	// ****************************************
	// Helpers
	// ****************************************
	// Polarity bit per pin, one means active high
	function automatic logic [PIN_COUNT-1:0] pin_polarity(input logic [7:0] cfg3, input logic [7:0] cfg4);
		logic [PIN_COUNT-1:0] p;
		p = '0;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (i < gsm_pkg::PINS_PER_CFG) begin
				p[i] = cfg3[gsm_pkg::POL_BIT_FIRST + gsm_pkg::POL_BIT_STRIDE * i];
			end else begin
				p[i] = cfg4[gsm_pkg::POL_BIT_FIRST + gsm_pkg::POL_BIT_STRIDE * (i - gsm_pkg::PINS_PER_CFG)];
			end
		end
		return p;
	endfunction

	// Engine channel to result slot; slot 4'hF means discard
	function automatic logic [3:0] chan_slot(input logic [3:0] ch, input logic aux9);
		logic [3:0] s;
		s = 4'hF;
		case (ch)
			gsm_pkg::CH_BATTERY: s = 4'h0;
			gsm_pkg::CH_AUX_INPUT_EIGHT: s = 4'h1;
			gsm_pkg::CH_REMOTE_TEMP_ONE: s = 4'h2;
			gsm_pkg::CH_REMOTE_TEMP_TWO: s = aux9 ? 4'hF : 4'h3;
			gsm_pkg::CH_AUX_INPUT_NINE: s = aux9 ? 4'h3 : 4'hF;
			gsm_pkg::CH_STANDBY_RAIL: s = 4'h4;
			gsm_pkg::CH_MAIN_RAIL: s = 4'h5;
			gsm_pkg::CH_FIVE_VOLT_RAIL: s = 4'h6;
			gsm_pkg::CH_CORE_SUPPLY: s = 4'h7;
			gsm_pkg::CH_PLUS_TWELVE_RAIL: s = 4'h8;
			gsm_pkg::CH_MINUS_TWELVE_RAIL: s = 4'h9;
			default: s = 4'hF;
		endcase
		return s;
	endfunction

	assign pol = pin_polarity(pin_cfg_three, pin_cfg_four);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [3:0] slot;
		logic [7:0] ridx;
		slot = chan_slot(meas_chan, shared_is_aux_nine);
		ridx = reg_addr - gsm_pkg::OFS_BATTERY_VOLTAGE;
		nxt_st = st_ff;
		nxt_st.pin_meta = upper_pin_in;
		nxt_st.pin_sync = st_ff.pin_meta;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (!pin_is_output[i]) begin
				// Level, not sticky: follows the pin while it is an input
				nxt_st.status[i] = ~(st_ff.pin_sync[i] ^ pol[i]);
			end else if (reg_wr && reg_addr == gsm_pkg::OFS_UPPER_PIN_STATUS) begin
				nxt_st.status[i] = reg_wdata[i];
			end
		end
		// Host writes to result offsets fall through untouched
		if (meas_valid && slot < gsm_pkg::RESULT_COUNT) begin
			nxt_st.result[slot] = meas_value;
		end
		// Pin drive follows the status bit in the same edge it is written
		nxt_st.pin_out = ~(nxt_st.status ^ pol);
		nxt_st.pin_oe = pin_is_output;
		if (reg_rd) begin
			if (reg_addr == gsm_pkg::OFS_UPPER_PIN_STATUS) begin
				nxt_st.rdata = st_ff.status;
			end else if (reg_addr >= gsm_pkg::OFS_BATTERY_VOLTAGE && reg_addr <= gsm_pkg::OFS_MINUS_TWELVE_RAIL) begin
				nxt_st.rdata = st_ff.result[ridx[3:0]];
			end else begin
				nxt_st.rdata = gsm_pkg::UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_ff.pin_meta <= '0;
			st_ff.pin_sync <= '0;
			st_ff.status <= gsm_pkg::RST_UPPER_PIN_STATUS;
			st_ff.result <= {gsm_pkg::RESULT_COUNT{gsm_pkg::RST_RESULT}};
			st_ff.rdata <= gsm_pkg::RST_READ_DATA;
			st_ff.pin_out <= '0;
			st_ff.pin_oe <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign upper_pin_out = st_ff.pin_out;
	assign upper_pin_oe = st_ff.pin_oe;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_input_tracks_pin: assert property (
		ce
		|=> ((st_ff.status ^ ~($past(st_ff.pin_sync) ^ $past(pol))) & ~$past(pin_is_output)) == '0
	)
	else $error("input status bit not tracking pin");

	// The edge right after reset still shows the cleared drive, so skip it
	a_drive_follows_bit: assert property (
		$past(ce) && !$past(reset)
		|-> st_ff.pin_out == ~(st_ff.status ^ $past(pol))
	)
	else $error("pin drive does not match status");

	a_oe_follows_dir: assert property (
		$past(ce) && !$past(reset)
		|-> upper_pin_oe == $past(pin_is_output)
	)
	else $error("pin enable does not match direction");

	a_polarity_low_half: assert property (
		ce && !pin_is_output[0] && pin_cfg_three[1] == 1'b0
		|=> st_ff.status[0] == ~$past(st_ff.pin_sync[0])
	)
	else $error("bad polarity on low half");

	a_polarity_low_high: assert property (
		ce && !pin_is_output[1] && pin_cfg_three[3] == 1'b1
		|=> st_ff.status[1] == $past(st_ff.pin_sync[1])
	)
	else $error("bad high polarity on low half");

	a_polarity_high_half: assert property (
		ce && !pin_is_output[7] && pin_cfg_four[7] == 1'b1
		|=> st_ff.status[7] == $past(st_ff.pin_sync[7])
	)
	else $error("bad polarity on high half");

	a_high_half_low: assert property (
		ce && !pin_is_output[4] && pin_cfg_four[1] == 1'b0
		|=> st_ff.status[4] == ~$past(st_ff.pin_sync[4])
	)
	else $error("bad low polarity on high half");

	a_write_outputs_only: assert property (
		ce && reg_wr && reg_addr == gsm_pkg::OFS_UPPER_PIN_STATUS
		|=> (st_ff.status & $past(pin_is_output)) == ($past(reg_wdata) & $past(pin_is_output))
	)
	else $error("status write lost");

	a_input_write_ignored: assert property (
		ce && reg_wr && reg_addr == gsm_pkg::OFS_UPPER_PIN_STATUS && !pin_is_output[4]
		|=> st_ff.status[4] == ~($past(st_ff.pin_sync[4]) ^ $past(pol[4]))
	)
	else $error("write reached an input bit");

	a_status_readback: assert property (
		ce && reg_rd && reg_addr == gsm_pkg::OFS_UPPER_PIN_STATUS
		|=> reg_rdata == $past(st_ff.status)
	)
	else $error("status readback wrong");

	a_unmapped_read: assert property (
		ce && reg_rd && (reg_addr < gsm_pkg::OFS_UPPER_PIN_STATUS || reg_addr > gsm_pkg::OFS_MINUS_TWELVE_RAIL)
		|=> reg_rdata == gsm_pkg::UNMAPPED_READ
	)
	else $error("unmapped read not zero");

	a_rdata_holds: assert property (
		!ce || !reg_rd
		|=> $stable(reg_rdata)
	)
	else $error("read data moved without a read");

	a_reset_clear: assert property (
		disable iff (1'b0) reset
		|=> reset || (st_ff.status == '0 && st_ff.result == '0)
	)
	else $error("reset value wrong");

	a_battery_update: assert property (
		(ce && meas_valid && meas_chan == gsm_pkg::CH_BATTERY) ##1 (ce && reg_rd && reg_addr == gsm_pkg::OFS_BATTERY_VOLTAGE)
		|=> reg_rdata == $past(meas_value, 2)
	)
	else $error("battery result wrong");

	a_aux_eight_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_AUX_INPUT_EIGHT
		|=> st_ff.result[1] == $past(meas_value)
	)
	else $error("aux eight result wrong");

	a_temp_one_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_REMOTE_TEMP_ONE
		|=> st_ff.result[2] == $past(meas_value)
	)
	else $error("remote temp one wrong");

	a_temp_two_update: assert property (
		ce && meas_valid && !shared_is_aux_nine && meas_chan == gsm_pkg::CH_REMOTE_TEMP_TWO
		|=> st_ff.result[3] == $past(meas_value)
	)
	else $error("remote temp two wrong");

	a_aux_nine_update: assert property (
		ce && meas_valid && shared_is_aux_nine && meas_chan == gsm_pkg::CH_AUX_INPUT_NINE
		|=> st_ff.result[3] == $past(meas_value)
	)
	else $error("aux nine result wrong");

	a_shared_select: assert property (
		ce && meas_valid && !shared_is_aux_nine && meas_chan == gsm_pkg::CH_AUX_INPUT_NINE
		|=> st_ff.result[3] == $past(st_ff.result[3])
	)
	else $error("deselected channel stored");

	a_temp_two_dropped: assert property (
		ce && meas_valid && shared_is_aux_nine && meas_chan == gsm_pkg::CH_REMOTE_TEMP_TWO
		|=> st_ff.result[3] == $past(st_ff.result[3])
	)
	else $error("deselected temp two stored");

	a_standby_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_STANDBY_RAIL
		|=> st_ff.result[4] == $past(meas_value)
	)
	else $error("standby rail wrong");

	a_main_rail_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_MAIN_RAIL
		|=> st_ff.result[5] == $past(meas_value)
	)
	else $error("main rail wrong");

	a_five_volt_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_FIVE_VOLT_RAIL
		|=> st_ff.result[6] == $past(meas_value)
	)
	else $error("five volt rail wrong");

	a_core_supply_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_CORE_SUPPLY
		|=> st_ff.result[7] == $past(meas_value)
	)
	else $error("core supply wrong");

	a_plus_twelve_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_PLUS_TWELVE_RAIL
		|=> st_ff.result[8] == $past(meas_value)
	)
	else $error("plus twelve wrong");

	a_minus_twelve_update: assert property (
		ce && meas_valid && meas_chan == gsm_pkg::CH_MINUS_TWELVE_RAIL
		|=> st_ff.result[9] == $past(meas_value)
	)
	else $error("minus twelve wrong");

	a_unknown_code_dropped: assert property (
		ce && meas_valid && meas_chan > gsm_pkg::CH_MINUS_TWELVE_RAIL
		|=> st_ff.result == $past(st_ff.result)
	)
	else $error("unknown channel code stored");

	a_results_host_proof: assert property (
		!meas_valid || !ce
		|=> st_ff.result == $past(st_ff.result)
	)
	else $error("result changed without engine");

	a_write_results_ignored: assert property (
		ce && !meas_valid && reg_wr && reg_addr >= gsm_pkg::OFS_BATTERY_VOLTAGE
		|=> st_ff.result == $past(st_ff.result)
	)
	else $error("host write reached a result");

	// Clock enable low must freeze the pin status as well as the results
	a_state_frozen: assert property (
		!ce
		|=> $stable(st_ff.status)
	)
	else $error("status moved while disabled");

	c_output_write: cover property (
		ce && reg_wr && reg_addr == gsm_pkg::OFS_UPPER_PIN_STATUS && pin_is_output != '0
	);

	c_input_assert: cover property (
		ce && !pin_is_output[0] ##3 st_ff.status[0]
	);

	c_shared_aux_nine: cover property (
		ce && meas_valid && shared_is_aux_nine && meas_chan == gsm_pkg::CH_AUX_INPUT_NINE
	);

	c_result_read: cover property (
		ce && reg_rd && reg_addr == gsm_pkg::OFS_CORE_SUPPLY
	);

	c_frozen_strobe: cover property (
		!ce && meas_valid
	);

endmodule

// *** hw/gsm_pkg.sv ***
// Constants for the upper pin status and measurement result register slice
// Function
// - Input pin: status bit shows one while the pin is asserted; read-only.
// - Output pin: pin is driven asserted whenever its status bit holds one.
// - Pins at status bits 0-3 take polarity from config register three bits 1,3,5,7.
// - Pins at status bits 4-7 take polarity from config register four bits 1,3,5,7.
// - Status bit writes take effect only for output pins; input bits ignore writes.
// - Upper pin status sits at 25h, resets to 00h, bit n is upper pin n.
// - Battery result is read-only at 26h, reset to 00h.
// - Auxiliary input eight result is read-only at 27h, reset to 00h.
// - Remote temperature one result is read-only at 28h, reset to 00h.
// - 29h holds remote temperature two or auxiliary nine, chosen by configuration.
// - 2Ah and 2Bh hold standby and main rail results, reset to 00h.
// - 2Ch-2Fh hold five volt, core, plus twelve, minus twelve results, reset 00h.
package gsm_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_UPPER_PIN_STATUS = 8'h25;
	localparam logic [7:0] OFS_BATTERY_VOLTAGE = 8'h26;
	localparam logic [7:0] OFS_AUX_INPUT_EIGHT = 8'h27;
	localparam logic [7:0] OFS_REMOTE_TEMP_ONE = 8'h28;
	localparam logic [7:0] OFS_REMOTE_TWO_OR_AUX_NINE = 8'h29;
	localparam logic [7:0] OFS_STANDBY_RAIL = 8'h2A;
	localparam logic [7:0] OFS_MAIN_RAIL = 8'h2B;
	localparam logic [7:0] OFS_FIVE_VOLT_RAIL = 8'h2C;
	localparam logic [7:0] OFS_CORE_SUPPLY = 8'h2D;
	localparam logic [7:0] OFS_PLUS_TWELVE_RAIL = 8'h2E;
	localparam logic [7:0] OFS_MINUS_TWELVE_RAIL = 8'h2F;

	// ****************************************
	// Reset values and geometry
	// ****************************************
	localparam logic [7:0] RST_UPPER_PIN_STATUS = 8'h00;
	localparam logic [7:0] RST_RESULT = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam int RESULT_COUNT = 10;
	localparam int PINS_PER_CFG = 4;
	localparam int POL_BIT_FIRST = 1;
	localparam int POL_BIT_STRIDE = 2;

	// ****************************************
	// Measurement engine channel codes
	// ****************************************
	localparam logic [3:0] CH_BATTERY = 4'h0;
	localparam logic [3:0] CH_AUX_INPUT_EIGHT = 4'h1;
	localparam logic [3:0] CH_REMOTE_TEMP_ONE = 4'h2;
	localparam logic [3:0] CH_REMOTE_TEMP_TWO = 4'h3;
	localparam logic [3:0] CH_AUX_INPUT_NINE = 4'h4;
	localparam logic [3:0] CH_STANDBY_RAIL = 4'h5;
	localparam logic [3:0] CH_MAIN_RAIL = 4'h6;
	localparam logic [3:0] CH_FIVE_VOLT_RAIL = 4'h7;
	localparam logic [3:0] CH_CORE_SUPPLY = 4'h8;
	localparam logic [3:0] CH_PLUS_TWELVE_RAIL = 4'h9;
	localparam logic [3:0] CH_MINUS_TWELVE_RAIL = 4'hA;

endpackage

// *** verif/gsm_host.sv ***
// Host model that reaches the register slice through its parallel strobe port
`timescale 1ns/10ps
module gsm_host (
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// ****************************************
	// Access tasks, one strobe cycle each
	// ****************************************
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines show the inverse so a stale value is never mistaken for a live one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the pin status and measurement result registers
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, upper_pin_out, upper_pin_oe;
	logic reg_wr, reg_rd, meas_valid = 1'b0;
	logic [7:0] upper_pin_in = 8'h50;
	logic [7:0] pin_is_output = 8'h0F;
	logic [7:0] pin_cfg_three = 8'hAA;
	logic [7:0] pin_cfg_four = 8'h00;
	logic shared_is_aux_nine = 1'b0;
	logic [3:0] meas_chan = 4'h0;
	logic [7:0] meas_value = 8'h00;
	int n_mismatch = 0;
	int n_tests = 0;
	always #50 clk_sys = ~clk_sys;
	gsm_host host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	gsm_regs dut_u (.clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .upper_pin_in(upper_pin_in),
		.upper_pin_out(upper_pin_out), .upper_pin_oe(upper_pin_oe), .pin_is_output(pin_is_output),
		.pin_cfg_three(pin_cfg_three), .pin_cfg_four(pin_cfg_four), .shared_is_aux_nine(shared_is_aux_nine),
		.meas_valid(meas_valid), .meas_chan(meas_chan), .meas_value(meas_value));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host_u.rd(a, d);
		`CHK(d, e)
	endtask
	task automatic meas(input logic [3:0] ch, input logic [7:0] v);
		@(negedge clk_sys);
		meas_valid = 1'b1;
		meas_chan = ch;
		meas_value = v;
		@(negedge clk_sys);
		meas_valid = 1'b0;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Offset fed by each engine channel code
	function automatic logic [7:0] ofs(input logic [3:0] ch);
		return (ch < 4'h5) ? ((ch == 4'h4) ? 8'h29 : 8'h26 + {4'h0, ch}) : 8'h25 + {4'h0, ch};
	endfunction
	initial begin
		#1000000;
		n_mismatch++;
		results();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (8) @(negedge clk_sys);
		reset = 1'b0;
		for (int a = 32'h26; a <= 32'h30; a++) chk_rd(8'(a), 8'h00);
		// Shared channel as remote temp two: the aux nine code must be dropped
		for (int c = 0; c <= 10; c++) meas(4'(c), {4'(c), ~4'(c)});
		for (int c = 0; c <= 10; c++) if (c != 4) chk_rd(ofs(4'(c)), {4'(c), ~4'(c)});
		host_u.wr(8'h26, 8'hFF);
		host_u.wr(8'h2F, 8'h00);
		chk_rd(8'h26, 8'h0F);
		chk_rd(8'h2F, 8'hA5);
		shared_is_aux_nine = 1'b1;
		meas(4'h3, 8'hC3);
		meas(4'h4, 8'h4D);
		chk_rd(8'h29, 8'h4D);
		// Unknown code is dropped, and a disabled clock ignores the engine strobe
		meas(4'hB, 8'h77);
		chk_rd(8'h2F, 8'hA5);
		ce = 1'b0;
		meas(4'h0, 8'h11);
		ce = 1'b1;
		chk_rd(8'h26, 8'h0F);
		// Pins 0-3 outputs active high, pins 4-7 inputs active low: only low inputs set bits
		host_u.wr(8'h25, 8'hFF);
		chk_rd(8'h25, 8'hAF);
		`CHK(upper_pin_out[3:0], 4'hF)
		`CHK(upper_pin_oe, 8'h0F)
		host_u.wr(8'h25, 8'h05);
		pin_cfg_three = 8'h00;
		upper_pin_in = 8'h00;
		repeat (4) @(negedge clk_sys);
		`CHK(upper_pin_out[3:0], 4'hA)
		chk_rd(8'h25, 8'hF5);
		// All pins inputs with mixed polarity on both halves
		pin_is_output = 8'h00;
		pin_cfg_three = 8'h08;
		pin_cfg_four = 8'h82;
		upper_pin_in = 8'h05;
		repeat (4) @(negedge clk_sys);
		chk_rd(8'h25, 8'h68);
		// Reset in mid-run clears the read data, enables and results
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		`CHK(reg_rdata, 8'h00)
		`CHK(upper_pin_oe, 8'h00)
		reset = 1'b0;
		chk_rd(8'h26, 8'h00);
		results();
	end
endmodule
